// ==== hdl/saux_fsm.v ====
// Sink auxiliary channel state machine with response timer
`default_nettype none
`include "saux_regs.vh"

// Notes on behaviour
// [RULE1] Reset forces not-ready state from anywhere
// [RULE2] Not-ready keeps hot-plug low, receiver off
// [RULE3] Without source detect, not-ready goes idle
// [RULE4] Leave not-ready only when ready, hot-plug raised
// [RULE5] With detect, no source gives source-absent state
// [RULE6] Source-absent goes idle once source detected
// [RULE7] Idle listens only, never drives the channel
// [RULE8] Invalid signal in idle keeps idle
// [RULE9] Request moves to reply-pending, restarts timer
// [RULE10] Listening always keeps activity detection alive
// [RULE11] Power saving ends promptly on input activity
// [RULE12] Always reply unless waking from power saving
// [RULE13] Reply-pending selects talk mode, prepares reply
// [RULE14] Reply finished returns to idle
// [RULE15] Timer expiry returns idle, no reply started
// [RULE16] Source retries unanswered requests three times
// [RULE17] Source waits up to 400 us for reply
// [RULE18] Transactions start with sync, end with stop
// [RULE19] Timer counts core cycles up to timeout
// [RULE20] Request counts only at valid well-formed stop
module saux_fsm #(
  parameter                  SRC_DETECT_EN = 0,
  parameter                  TMR_W         = `SAUX_TMR_W,
  parameter [TMR_W-1:0]      RESP_CYCLES   = `SAUX_RESP_CYC
) (
  input  wire                mclk_in,
  input  wire                rst_in,
  input  wire                sink_ready_in,
  input  wire                source_present_in,
  input  wire                sig_detect_in,
  input  wire                req_valid_in,
  input  wire                rx_error_in,
  input  wire                reply_done_in,
  input  wire                sleep_req_in,
  output reg  [`SAUX_ST_W-1:0] state_out,
  output reg                 hot_plug_signal_out,
  output reg                 rx_en_out,
  output reg                 tx_en_out,
  output reg                 reply_go_out,
  output reg                 timeout_out,
  output reg                 low_power_out,
  output reg                 wake_out
);

  localparam [`SAUX_ST_W-1:0] SINK_NOT_READY_STATE  = `SAUX_ST_NOT_READY;
  localparam [`SAUX_ST_W-1:0] SOURCE_ABSENT_STATE   = `SAUX_ST_SRC_ABSENT;
  localparam [`SAUX_ST_W-1:0] IDLE_LISTEN_STATE     = `SAUX_ST_IDLE_LISTEN;
  localparam [`SAUX_ST_W-1:0] REPLY_PENDING_STATE   = `SAUX_ST_REPLY_PEND;
  localparam [TMR_W-1:0]      TMR_LAST              = RESP_CYCLES - {{(TMR_W-1){1'b0}}, 1'b1};
  localparam [TMR_W-1:0]      TMR_ZERO              = {TMR_W{1'b0}};

  // Filtered level: follow only when the last two sync stages agree
  function filt;
    input [2:0] sync;
    input       prev;
    begin
      if (sync[1] == sync[2])
        filt = sync[2];
      else
        filt = prev;
    end
  endfunction

  reg  [`SAUX_ST_W-1:0] state_reg;
  reg  [`SAUX_ST_W-1:0] state_next;
  reg  [TMR_W-1:0]      tmr_reg;
  reg  [TMR_W-1:0]      tmr_next;
  reg  [2:0]            src_sync_reg;
  reg  [2:0]            sig_sync_reg;
  reg                   src_lvl_reg;
  reg                   sig_lvl_reg;
  reg                   sig_lvl_d_reg;
  reg                   hpd_next;
  reg                   rx_en_next;
  reg                   tx_en_next;
  reg                   reply_go_next;
  reg                   timeout_next;
  reg                   low_power_next;
  reg                   wake_next;
  wire                  sig_rise;
  wire                  tmr_done;

  assign sig_rise = sig_lvl_reg & ~sig_lvl_d_reg;
  assign tmr_done = (tmr_reg == TMR_LAST);

  // Source-detect pin: three stages, then the agree filter
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      src_sync_reg <= `SAUX_SYNC_RST;
      src_lvl_reg  <= 1'b0;
    end
    else
    begin
      src_sync_reg <= {src_sync_reg[1:0], source_present_in};
      src_lvl_reg  <= filt(src_sync_reg, src_lvl_reg);
    end
  end

  // Activity pin: same filter, plus a delayed copy for edge finding
  // The delayed copy resets to the idle pin level, so no false edge
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      sig_sync_reg  <= `SAUX_SYNC_RST;
      sig_lvl_reg   <= 1'b0;
      sig_lvl_d_reg <= 1'b0;
    end
    else
    begin
      sig_sync_reg  <= {sig_sync_reg[1:0], sig_detect_in};
      sig_lvl_reg   <= filt(sig_sync_reg, sig_lvl_reg); // [RULE10]
      sig_lvl_d_reg <= sig_lvl_reg;
    end
  end

  // Next state and output decode
  always @*
  begin
    state_next     = state_reg;
    tmr_next       = tmr_reg;
    hpd_next       = hot_plug_signal_out;
    rx_en_next     = 1'b1;
    tx_en_next     = 1'b0;
    reply_go_next  = 1'b0;
    timeout_next   = 1'b0;
    low_power_next = low_power_out;
    wake_next      = 1'b0;
    case (state_reg)
      SINK_NOT_READY_STATE:
      begin
        hpd_next       = 1'b0; // [RULE2]
        rx_en_next     = 1'b0; // [RULE2]
        low_power_next = 1'b0;
        if (sink_ready_in)
        begin
          // Hot-plug rises on the same edge that leaves not-ready
          hpd_next   = 1'b1; // [RULE4]
          rx_en_next = 1'b1;
          if ((SRC_DETECT_EN != 0) && !src_lvl_reg)
            state_next = SOURCE_ABSENT_STATE; // [RULE5]
          else
            state_next = IDLE_LISTEN_STATE; // [RULE3] [RULE4]
        end
      end
      SOURCE_ABSENT_STATE:
      begin
        if (src_lvl_reg)
          state_next = IDLE_LISTEN_STATE; // [RULE6]
      end
      IDLE_LISTEN_STATE:
      begin
        // Receive only; decode errors leave the state alone
        tx_en_next = 1'b0; // [RULE7] [RULE8]
        if (low_power_out)
        begin
          if (sig_lvl_reg)
          begin
            low_power_next = 1'b0; // [RULE11]
            wake_next      = 1'b1; // [RULE11]
          end
        end
        else if (req_valid_in)
        begin
          state_next    = REPLY_PENDING_STATE; // [RULE9] [RULE18] [RULE20]
          tmr_next      = TMR_ZERO; // [RULE9]
          tx_en_next    = 1'b1; // [RULE13]
          rx_en_next    = 1'b0;
          reply_go_next = 1'b1; // [RULE13] [RULE12]
        end
        else if (sleep_req_in && !sig_lvl_reg && !sig_rise && !rx_error_in)
          low_power_next = 1'b1;
      end
      REPLY_PENDING_STATE:
      begin
        tx_en_next = 1'b1; // [RULE13]
        rx_en_next = 1'b0;
        tmr_next   = tmr_reg + {{(TMR_W-1){1'b0}}, 1'b1}; // [RULE19]
        if (reply_done_in)
        begin
          state_next = IDLE_LISTEN_STATE; // [RULE14]
          tx_en_next = 1'b0;
          rx_en_next = 1'b1;
        end
        else if (tmr_done)
        begin
          state_next   = IDLE_LISTEN_STATE; // [RULE15]
          timeout_next = 1'b1; // [RULE15]
          tx_en_next   = 1'b0;
          rx_en_next   = 1'b1;
        end
      end
      default:
      begin
        state_next = SINK_NOT_READY_STATE;
        hpd_next   = 1'b0;
        rx_en_next = 1'b0;
      end
    endcase
  end

  // State and response timer
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_reg <= SINK_NOT_READY_STATE; // [RULE1]
      tmr_reg   <= TMR_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
    end
  end

  // Every output is a flop loaded from its next value
  always @(posedge mclk_in)
  begin
    if (rst_in)
      state_out <= SINK_NOT_READY_STATE;
    else
      state_out <= state_next;
  end

  // Hot-plug stays low through reset and not-ready
  always @(posedge mclk_in)
  begin
    if (rst_in)
      hot_plug_signal_out <= 1'b0; // [RULE2]
    else
      hot_plug_signal_out <= hpd_next;
  end

  always @(posedge mclk_in)
  begin
    if (rst_in)
      rx_en_out <= 1'b0;
    else
      rx_en_out <= rx_en_next;
  end

  always @(posedge mclk_in)
  begin
    if (rst_in)
      tx_en_out <= 1'b0;
    else
      tx_en_out <= tx_en_next;
  end

  // One-cycle pulses: reply start, timeout, wake
  always @(posedge mclk_in)
  begin
    if (rst_in)
      reply_go_out <= 1'b0;
    else
      reply_go_out <= reply_go_next;
  end

  always @(posedge mclk_in)
  begin
    if (rst_in)
      timeout_out <= 1'b0;
    else
      timeout_out <= timeout_next;
  end

  always @(posedge mclk_in)
  begin
    if (rst_in)
      low_power_out <= 1'b0;
    else
      low_power_out <= low_power_next;
  end

  always @(posedge mclk_in)
  begin
    if (rst_in)
      wake_out <= 1'b0;
    else
      wake_out <= wake_next;
  end

endmodule // saux_fsm

`default_nettype wire

// ==== hdl/saux_regs.vh ====
// Constants for the sink auxiliary channel state machine
`ifndef SAUX_REGS_VH
`define SAUX_REGS_VH

// State codes
`define SAUX_ST_W              2
`define SAUX_ST_NOT_READY      2'h0
`define SAUX_ST_SRC_ABSENT     2'h1
`define SAUX_ST_IDLE_LISTEN    2'h2
`define SAUX_ST_REPLY_PEND     2'h3

// Core clock rate and response timeout
`define SAUX_CLK_MHZ           16'd100
`define SAUX_RESP_TIME_US      16'd300
`define SAUX_RESP_CYC          (`SAUX_RESP_TIME_US * `SAUX_CLK_MHZ)
`define SAUX_TMR_W             16

// Reset values
`define SAUX_SYNC_RST          3'h0

`endif

// ==== tb/saux_fsm_asserts.sv ====
// Concurrent checks on the sink auxiliary channel state machine ports
`default_nettype none
module saux_fsm_asserts #(parameter [15:0] RESP_CYCLES = 16'h7530) (
  input wire logic       mclk_in, rst_in, sink_ready_in, source_present_in, sig_detect_in,
  input wire logic       req_valid_in, rx_error_in, reply_done_in, sleep_req_in,
  input wire logic [1:0] state_out,
  input wire logic       hot_plug_signal_out, rx_en_out, tx_en_out, reply_go_out,
  input wire logic       timeout_out, low_power_out, wake_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  int cnt_reg = 0;
  always_ff @(posedge mclk_in)
    cnt_reg <= (rst_in || state_out != 2'h3) ? 0 : cnt_reg + 1;
  sequence s_req;
    state_out == 2'h2 && req_valid_in && !low_power_out;
  endsequence
  sequence s_talk;
    state_out == 2'h3 && reply_go_out && tx_en_out && !rx_en_out;
  endsequence
  rst_state_a: assert property (rst_in |=> state_out == 2'h0)
    else $error("state not cleared by reset");
  nr_hpd_a: assert property (state_out == 2'h0 |-> !hot_plug_signal_out)
    else $error("hot-plug high while not ready");
  nr_leave_a: assert property (disable iff (rst_in)
    $past(state_out) == 2'h0 && state_out != 2'h0 |-> hot_plug_signal_out && $past(sink_ready_in))
    else $error("left not-ready without readiness");
  idle_listen_a: assert property (state_out == 2'h2 |-> rx_en_out && !tx_en_out)
    else $error("idle not listening");
  err_stay_a: assert property (disable iff (rst_in)
    state_out == 2'h2 && rx_error_in && !req_valid_in |=> state_out == 2'h2)
    else $error("invalid signal left idle");
  req_talk_a: assert property (disable iff (rst_in) s_req |=> s_talk ##1 !reply_go_out)
    else $error("request not answered by talk mode");
  done_idle_a: assert property (disable iff (rst_in)
    state_out == 2'h3 && reply_done_in |=> state_out == 2'h2 && !timeout_out)
    else $error("reply finish did not return idle");
  tmr_expiry_a: assert property (disable iff (rst_in)
    timeout_out |-> cnt_reg == RESP_CYCLES && state_out == 2'h2 && !reply_go_out)
    else $error("timeout at wrong count");
  tmr_bound_a: assert property (cnt_reg <= RESP_CYCLES)
    else $error("reply pending beyond timeout");
  wake_exit_a: assert property (disable iff (rst_in) wake_out |-> !low_power_out)
    else $error("wake without leaving power saving");
endmodule // saux_fsm_asserts
bind saux_fsm saux_fsm_asserts #(.RESP_CYCLES(RESP_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== tb/saux_src_model.sv ====
// Source requester model: sends requests, waits for a reply, retries
`default_nettype none
module saux_src_model #(parameter int WAIT = 40) (
  input wire logic clk_in, go_in, reply_in,
  output var logic req_out, sig_out,
  output var int   tries_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {req_out, sig_out, tries_out} = 0;
  always
  begin : req_loop
    int i, n;
    logic got;
    @(posedge go_in);
    got = 0;
    for (i = 0; i < 4 && !got; i++)
    begin
      @(negedge clk_in) sig_out = 1;
      tries_out++;
      repeat (3) @(negedge clk_in);
      req_out = 1;
      @(negedge clk_in) {req_out, sig_out} = 2'h0;
      for (n = 0; n < WAIT && !got; n++)
      begin
        @(posedge clk_in) got = reply_in;
      end
    end
  end
endmodule // saux_src_model
`default_nettype wire

// ==== tb/saux_tb.sv ====
// Self-checking bench for the sink auxiliary channel state machine
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk_in, rst_in, sink_ready_in, source_present_in, sleep_req_in;
  logic       rx_error_in, reply_done_in, go, sig_detect_in, req_valid_in;
  logic [1:0] state_out;
  logic       hot_plug_signal_out, rx_en_out, tx_en_out, reply_go_out;
  logic       timeout_out, low_power_out, wake_out;
  int         num_errors = 0, n_checks = 0, tries, n;
  saux_fsm #(.SRC_DETECT_EN(1), .RESP_CYCLES(16'h0014)) dut (.*);
  saux_src_model #(.WAIT(40)) src (.clk_in(mclk_in), .go_in(go), .reply_in(reply_go_out),
    .req_out(req_valid_in), .sig_out(sig_detect_in), .tries_out(tries));
  initial
  begin
    mclk_in = 0;
    forever #5 mclk_in = ~mclk_in;
  end
  task chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int k); repeat (k) @(negedge mclk_in); endtask
  task wait_st(input logic [1:0] s);
    for (int k = 0; k < 100 && state_out !== s; k++) cyc(1);
  endtask
  task send; go = 1; cyc(1); go = 0; endtask
  task pulse_done; reply_done_in = 1; cyc(1); reply_done_in = 0; endtask
  task t_start;
    rst_in = 1; cyc(5);
    chk(state_out, 2'h0);
    chk(hot_plug_signal_out, 1'h0);
    rst_in = 0; wait_st(2'h1);
    chk(state_out, 2'h1);
    chk(hot_plug_signal_out, 1'h1);
    source_present_in = 1; wait_st(2'h2);
    chk(state_out, 2'h2);
    chk({rx_en_out, tx_en_out}, 2'h2);
  endtask
  task t_reply;
    rx_error_in = 1; cyc(1); rx_error_in = 0;
    chk(state_out, 2'h2);
    send; wait_st(2'h3);
    chk({rx_en_out, tx_en_out}, 2'h1);
    pulse_done;
    chk({state_out, timeout_out}, 3'h4);
    cyc(50);
  endtask
  task t_timeout;
    send; wait_st(2'h3);
    for (n = 0; n < 100 && state_out === 2'h3; n++) cyc(1);
    chk(n, 16'h0014);
    chk({timeout_out, reply_go_out, state_out}, 4'ha);
    cyc(50); send; wait_st(2'h3);
    rst_in = 1; cyc(1);
    chk(state_out, 2'h0);
    rst_in = 0; wait_st(2'h2);
    chk(state_out, 2'h2);
  endtask
  task t_sleep;
    sleep_req_in = 1; cyc(3);
    chk(low_power_out, 1'h1);
    send;
    for (n = 0; n < 100 && wake_out !== 1'h1; n++) cyc(1);
    chk({wake_out, low_power_out}, 2'h2);
    sleep_req_in = 0; wait_st(2'h3);
    chk(state_out, 2'h3);
    pulse_done;
  endtask
  task finish_test;
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #20us num_errors++;
    finish_test;
  end
  initial
  begin
    {rst_in, source_present_in, sleep_req_in, rx_error_in, reply_done_in, go} = 6'h20;
    sink_ready_in = 1;
    t_start; t_reply; t_timeout; t_sleep;
    finish_test;
  end
endmodule // tb
`default_nettype wire
